// ---- core/dps_spi_slave.sv ----
// Serial slave front end of a dual digital potentiometer.
// Assumes all pins are asynchronous to CLK_SYS and much slower than it.
//
// What this block does
// - Read data leaves the serial output, changing on serial clock falling edges.
// - Serial input is sampled on each rising serial clock edge.
// - Hold while selected freezes bit position and partial command.
// - Proceed only when the received 4-bit address equals the address pins.
// - Chip select high deselects and tristates the serial output.
// - Deselected means standby, unless a nonvolatile write is still running.
// - Chip select low activates the device for serial traffic.
// - Nothing is accepted after power-up until chip select falls.
// - Power-up copies each pot's default register into its wiper.
// - Each pot has one wiper and four nonvolatile registers, all accessible.
// - Each wiper value selects exactly one of 256 taps.
// - The 8-bit wiper decodes to a one-hot enable of 256 switches.
// - First byte holds type code above and slave address below.
// - Second byte holds opcode, register select and pot select.
// - Write protect low blocks every nonvolatile register write.
module dps_spi_slave #(
  parameter int unsigned NV_WRITE_CYC = dps_pkg::NV_WRITE_CYCLES
) (
  // System
  input  wire logic         CLK_SYS,
  input  wire logic         NRST,
  // Serial pins
  input  wire logic         CS_N,
  input  wire logic         SCK,
  input  wire logic         SI,
  input  wire logic         HOLD_N,
  output logic              SO,
  output logic              SO_OE,
  // Straps and protection
  input  wire logic [3:0]   SLAVE_ADDR_PINS,
  input  wire logic         WP_N,
  // Pot side
  output logic [7:0]        WIPER_POS0,
  output logic [7:0]        WIPER_POS1,
  output logic [255:0]      TAP_EN0,
  output logic [255:0]      TAP_EN1,
  output logic              STANDBY
);

  // ==========================================================================
  // Synchronisers
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       hold_s;
  logic       wp_s;
  logic [3:0] addr_s;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sync1_reg <= dps_pkg::SYNC_RST;
      sync2_reg <= dps_pkg::SYNC_RST;
    end else begin
      sync1_reg <= {CS_N, SCK, SI, HOLD_N, WP_N, SLAVE_ADDR_PINS};
      sync2_reg <= sync1_reg;
    end
  end

  assign cs_s   = sync2_reg[8];
  assign sck_s  = sync2_reg[7];
  assign si_s   = sync2_reg[6];
  assign hold_s = sync2_reg[5];
  assign wp_s   = sync2_reg[4];
  assign addr_s = sync2_reg[3:0];

  // ==========================================================================
  // State
  dps_pkg::dps_state_t                 state_reg,   state_next;
  logic [dps_pkg::BIT_CNT_W-1:0]       bit_reg,     bit_next;
  logic [7:0]                          shift_reg,   shift_next;
  logic [7:0]                          instr_reg,   instr_next;
  logic [7:0]                          out_reg,     out_next;
  logic                                so_reg,      so_next;
  logic                                sck_d_reg;
  logic                                cs_d_reg;
  logic                                recall_reg,  recall_next;
  logic                                armed_reg,   armed_next;
  logic                                boot_reg;
  logic [dps_pkg::NV_CNT_W-1:0]        busy_reg,    busy_next;
  logic                                standby_reg, standby_next;
  logic [1:0][7:0]                     wiper_reg,   wiper_next;
  logic [1:0][3:0][7:0]                nv_reg,      nv_next;

  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       frozen;
  logic       nv_ok;
  logic [7:0] byte_in;
  logic [3:0] op;
  logic [1:0] rsel;
  logic       pot;

  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  // A select already low when reset ends is no falling edge: the synchroniser
  // shows its idle reset value for two edges, so arm only on a real high.
  assign cs_fall  = ~cs_s & cs_d_reg & armed_reg;
  assign frozen   = ~cs_s & ~hold_s;
  assign nv_ok    = wp_s && (busy_reg == '0);
  assign byte_in  = {shift_reg[6:0], si_s};
  assign op       = instr_reg[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO];
  assign rsel     = instr_reg[dps_pkg::INS_REG_HI:dps_pkg::INS_REG_LO];
  assign pot      = instr_reg[dps_pkg::INS_POT_BIT];

  // ==========================================================================
  // Next state
  always_comb begin
    logic [3:0] b_op;
    logic [1:0] b_rsel;
    logic       b_pot;
    b_op         = byte_in[dps_pkg::INS_OP_HI:dps_pkg::INS_OP_LO];
    b_rsel       = byte_in[dps_pkg::INS_REG_HI:dps_pkg::INS_REG_LO];
    b_pot        = byte_in[dps_pkg::INS_POT_BIT];
    state_next   = state_reg;
    bit_next     = bit_reg;
    shift_next   = shift_reg;
    instr_next   = instr_reg;
    out_next     = out_reg;
    so_next      = so_reg;
    recall_next  = 1'b0;
    armed_next   = armed_reg | (cs_s & ~boot_reg);
    wiper_next   = wiper_reg;
    nv_next      = nv_reg;
    busy_next    = busy_reg;
    if (busy_reg != '0) begin
      busy_next = busy_reg - 1'b1;
    end
    if (recall_reg) begin
      wiper_next[0] = nv_reg[0][0];
      wiper_next[1] = nv_reg[1][0];
    end
    if (cs_s) begin
      state_next = dps_pkg::ST_IDLE;
    end else if (cs_fall) begin
      // Only a falling select leaves idle, so power-up traffic is ignored.
      state_next = dps_pkg::ST_ID;
      bit_next   = '0;
    end else if (!frozen) begin
      if (sck_rise && (state_reg inside
          {dps_pkg::ST_ID, dps_pkg::ST_INS, dps_pkg::ST_DIN})) begin
        shift_next = byte_in;
        bit_next   = bit_reg + 1'b1;
        if (bit_reg == dps_pkg::BYTE_LAST) begin
          bit_next = '0;
          case (state_reg)
            dps_pkg::ST_ID: begin
              if (byte_in[dps_pkg::ID_TYPE_HI:dps_pkg::ID_TYPE_LO]
                  == dps_pkg::DEV_TYPE &&
                  byte_in[dps_pkg::ID_ADDR_HI:dps_pkg::ID_ADDR_LO]
                  == addr_s) begin
                state_next = dps_pkg::ST_INS;
              end else begin
                state_next = dps_pkg::ST_IGNORE;
              end
            end
            dps_pkg::ST_INS: begin
              instr_next = byte_in;
              state_next = dps_pkg::ST_IGNORE;
              case (b_op)
                dps_pkg::OP_RD_WIPER: begin
                  out_next   = wiper_reg[b_pot];
                  state_next = dps_pkg::ST_DOUT;
                end
                dps_pkg::OP_RD_NV: begin
                  out_next   = nv_reg[b_pot][b_rsel];
                  state_next = dps_pkg::ST_DOUT;
                end
                dps_pkg::OP_RD_STATUS: begin
                  out_next   = {7'h00, busy_reg != '0};
                  state_next = dps_pkg::ST_DOUT;
                end
                dps_pkg::OP_WR_WIPER,
                dps_pkg::OP_WR_NV: begin
                  state_next = dps_pkg::ST_DIN;
                end
                dps_pkg::OP_NV_TO_WIP: begin
                  wiper_next[b_pot] = nv_reg[b_pot][b_rsel];
                end
                dps_pkg::OP_WIP_TO_NV: begin
                  if (nv_ok) begin
                    nv_next[b_pot][b_rsel] = wiper_reg[b_pot];
                    busy_next = dps_pkg::NV_CNT_W'(NV_WRITE_CYC);
                  end
                end
                default: begin
                  state_next = dps_pkg::ST_IGNORE;
                end
              endcase
            end
            dps_pkg::ST_DIN: begin
              state_next = dps_pkg::ST_IGNORE;
              if (op == dps_pkg::OP_WR_WIPER) begin
                wiper_next[pot] = byte_in;
              end else if (nv_ok) begin
                nv_next[pot][rsel] = byte_in;
                busy_next = dps_pkg::NV_CNT_W'(NV_WRITE_CYC);
              end
            end
            default: begin
              state_next = dps_pkg::ST_IGNORE;
            end
          endcase
        end
      end
      // The last bit stays on the pin until the following falling edge.
      if (sck_fall && state_reg == dps_pkg::ST_DOUT) begin
        if (bit_reg == dps_pkg::OUT_BITS) begin
          state_next = dps_pkg::ST_IGNORE;
        end else begin
          so_next  = out_reg[7];
          out_next = {out_reg[6:0], 1'b0};
          bit_next = bit_reg + 1'b1;
        end
      end
    end
    standby_next = cs_s && (busy_next == '0);
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_reg   <= dps_pkg::ST_IDLE;
      bit_reg     <= '0;
      shift_reg   <= '0;
      instr_reg   <= '0;
      out_reg     <= '0;
      so_reg      <= 1'b0;
      sck_d_reg   <= 1'b0;
      cs_d_reg    <= 1'b1;
      recall_reg  <= 1'b1;
      armed_reg   <= 1'b0;
      boot_reg    <= 1'b1;
      busy_reg    <= '0;
      standby_reg <= 1'b1;
      wiper_reg   <= '0;
      nv_reg      <= {8{dps_pkg::NV_RESET}};
    end else begin
      state_reg   <= state_next;
      bit_reg     <= bit_next;
      shift_reg   <= shift_next;
      instr_reg   <= instr_next;
      out_reg     <= out_next;
      so_reg      <= so_next;
      sck_d_reg   <= sck_s;
      cs_d_reg    <= cs_s;
      recall_reg  <= recall_next;
      armed_reg   <= armed_next;
      boot_reg    <= recall_reg;
      busy_reg    <= busy_next;
      standby_reg <= standby_next;
      wiper_reg   <= wiper_next;
      nv_reg      <= nv_next;
    end
  end

  // ==========================================================================
  // Outputs and tap decoders
  // The output floats during a pause so a shared data line can be reused.
  assign SO_OE      = (state_reg == dps_pkg::ST_DOUT) & ~cs_s & hold_s;
  assign SO         = so_reg;
  assign STANDBY    = standby_reg;
  assign WIPER_POS0 = wiper_reg[0];
  assign WIPER_POS1 = wiper_reg[1];

  dps_tap_if tap0 ();
  dps_tap_if tap1 ();
  assign tap0.pos = wiper_reg[0];
  assign tap1.pos = wiper_reg[1];
  assign TAP_EN0  = tap0.en;
  assign TAP_EN1  = tap1.en;

  dps_tap_decode u_dec0 (.tap(tap0.dec));
  dps_tap_decode u_dec1 (.tap(tap1.dec));

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  sequence s_live_rise;
    !cs_s && hold_s && sck_rise;
  endsequence

  sequence s_id_done;
    s_live_rise ##0 (state_reg == dps_pkg::ST_ID) ##0
      (bit_reg == dps_pkg::BYTE_LAST);
  endsequence

  a_so_tristate: assert property (cs_s |-> !SO_OE ##1
      (state_reg == dps_pkg::ST_IDLE))
    else $error("serial output driven while deselected");
  a_boot_idle: assert property (!armed_reg |=>
      state_reg == dps_pkg::ST_IDLE)
    else $error("frame started before a select fall");
  a_si_sampled: assert property (s_live_rise ##0 (state_reg inside
      {dps_pkg::ST_ID, dps_pkg::ST_INS, dps_pkg::ST_DIN})
      |=> shift_reg[0] == $past(si_s))
    else $error("serial input not sampled on rising edge");
  a_so_on_fall: assert property ($changed(so_reg) |-> $past(sck_fall))
    else $error("serial output changed off a falling edge");
  a_hold_freeze: assert property (frozen ##1 frozen
      |-> $stable(bit_reg) && $stable(state_reg))
    else $error("serial state moved during hold");
  a_addr_miss: assert property (s_id_done ##0
      (byte_in[3:0] != addr_s) |=> state_reg == dps_pkg::ST_IGNORE)
    else $error("mismatched address not ignored");
  a_sel_start: assert property ((cs_fall && !cs_s) |=>
      state_reg == dps_pkg::ST_ID && bit_reg == '0)
    else $error("falling select did not start a frame");
  a_recall_load: assert property ($rose(NRST) ##0 recall_reg |=>
      wiper_reg[0] == $past(nv_reg[0][0]))
    else $error("default register not recalled");
  a_wp_block: assert property (!wp_s |=> $stable(nv_reg))
    else $error("nonvolatile write while protected");
  a_standby: assert property ((busy_reg != '0) |-> !STANDBY)
    else $error("standby during a nonvolatile write");
  a_tap_onehot: assert property ($onehot(TAP_EN0) &&
      TAP_EN0[WIPER_POS0] && $onehot(TAP_EN1) &&
      TAP_EN1[WIPER_POS1])
    else $error("tap enable not one-hot on the wiper");

endmodule : dps_spi_slave

// ---- core/dps_pkg.sv ----
// Constants shared by the dual pot serial front end and its testbench.
// Assumes a 100 MHz system clock that samples every serial pin.
package dps_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned NV_WRITE_NS     = 10_000_000;
  localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_NS / CLK_PERIOD_NS;
  localparam int unsigned NV_CNT_W        = 20;

  // ==========================================================================
  // Geometry
  localparam int unsigned POT_COUNT = 2;
  localparam int unsigned NV_COUNT  = 4;
  localparam int unsigned TAP_COUNT = 256;
  localparam int unsigned BIT_CNT_W = 4;

  // ==========================================================================
  // Frame fields
  localparam int unsigned ID_TYPE_HI  = 7;
  localparam int unsigned ID_TYPE_LO  = 4;
  localparam int unsigned ID_ADDR_HI  = 3;
  localparam int unsigned ID_ADDR_LO  = 0;
  localparam int unsigned INS_OP_HI   = 7;
  localparam int unsigned INS_OP_LO   = 4;
  localparam int unsigned INS_REG_HI  = 3;
  localparam int unsigned INS_REG_LO  = 2;
  localparam int unsigned INS_POT_BIT = 0;
  localparam logic [3:0]  BYTE_LAST   = 4'h7;
  localparam logic [3:0]  OUT_BITS    = 4'h8;

  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE = 4'hA;

  // ==========================================================================
  // Opcodes
  localparam logic [3:0] OP_RD_STATUS = 4'h5;
  localparam logic [3:0] OP_RD_WIPER  = 4'h9;
  localparam logic [3:0] OP_WR_WIPER  = 4'hA;
  localparam logic [3:0] OP_RD_NV     = 4'hB;
  localparam logic [3:0] OP_WR_NV     = 4'hC;
  localparam logic [3:0] OP_NV_TO_WIP = 4'hD;
  localparam logic [3:0] OP_WIP_TO_NV = 4'hE;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] NV_RESET  = 8'h80;
  localparam logic [8:0] SYNC_RST  = 9'h130;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ID     = 6'h02,
    ST_INS    = 6'h04,
    ST_DIN    = 6'h08,
    ST_DOUT   = 6'h10,
    ST_IGNORE = 6'h20
  } dps_state_t;

endpackage : dps_pkg

// ---- core/dps_tap_if.sv ----
// Wiper position and its one-hot tap enable, between front end and decoder.
// Assumes the decoder is purely combinational.
interface dps_tap_if;
  logic [7:0]   pos;
  logic [255:0] en;
  modport drv (output pos, input en);
  modport dec (input pos, output en);
endinterface : dps_tap_if

// ---- core/dps_tap_decode.sv ----
// Decodes an 8-bit wiper position into one enable among 256 tap switches.
// Assumes the position comes from a register, so the output is glitch-safe.
module dps_tap_decode (
  // Tap link
  dps_tap_if.dec tap
);

  // ==========================================================================
  // Decode
  always_comb begin
    tap.en           = '0;
    tap.en[tap.pos]  = 1'b1;
  end

endmodule : dps_tap_decode

// ---- tb/dps_host_model.sv ----
// Serial host model that frames commands toward the pot front end.
// Assumes it is started at a falling CLK_SYS edge; SCK rests low between frames.
module dps_host_model (
  // System
  input  wire logic CLK_SYS,
  // Serial pins
  output logic      CS_N,
  output logic      SCK,
  output logic      SI,
  output logic      HOLD_N,
  input  wire logic SO,
  input  wire logic SO_OE
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Link state
  localparam time HALF = 80ns;
  logic so_last;

  initial begin
    CS_N    = 1'b1;
    SCK     = 1'b0;
    SI      = 1'b0;
    HOLD_N  = 1'b1;
    so_last = 1'b0;
  end

  // ==========================================================================
  // One frame; the undriven output line reads as the inverse of its last bit.
  task automatic xfer(input logic [23:0] bits, input int nbits,
                      input int hold_at, input bit keep_sel,
                      output logic [7:0] rd, output logic oe_all);
    int   i;
    logic b;
    rd     = 8'h00;
    oe_all = 1'b1;
    @(negedge CLK_SYS);
    CS_N = 1'b0;
    #(HALF);
    for (i = 0; i < nbits; i++) begin
      SI = bits[23-i];
      if (i == hold_at) begin
        HOLD_N = 1'b0;
        #(HALF);
        SCK = 1'b1;
        SI  = ~SI;
        #(HALF);
        SCK = 1'b0;
        SI  = bits[23-i];
        #(HALF);
        HOLD_N = 1'b1;
      end
      #(HALF);
      SCK     = 1'b1;
      b       = SO_OE ? SO : ~so_last;
      so_last = b;
      if (i >= 16) begin
        rd     = {rd[6:0], b};
        oe_all = oe_all & SO_OE;
      end
      #(HALF);
      SCK = 1'b0;
    end
    #(HALF);
    if (!keep_sel) begin
      CS_N = 1'b1;
    end
  endtask : xfer
endmodule : dps_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the dual pot serial front end.
// Assumes the host model drives the serial pins; inputs change on CLK_SYS fall.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  localparam int unsigned NVW  = 50;
  localparam logic [3:0]  ADDR = 4'h6;
  logic         CLK_SYS;
  logic         NRST;
  logic         WP_N;
  logic [3:0]   SLAVE_ADDR_PINS;
  logic         CS_N;
  logic         SCK;
  logic         SI;
  logic         HOLD_N;
  logic         SO;
  logic         SO_OE;
  logic [7:0]   WIPER_POS0;
  logic [7:0]   WIPER_POS1;
  logic [255:0] TAP_EN0;
  logic [255:0] TAP_EN1;
  logic         STANDBY;
  int           mismatches;
  int           checks;
  logic [7:0]   rd;
  logic         oe;

  dps_spi_slave #(.NV_WRITE_CYC(NVW)) uut (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .CS_N(CS_N), .SCK(SCK), .SI(SI),
    .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE),
    .SLAVE_ADDR_PINS(SLAVE_ADDR_PINS), .WP_N(WP_N),
    .WIPER_POS0(WIPER_POS0), .WIPER_POS1(WIPER_POS1),
    .TAP_EN0(TAP_EN0), .TAP_EN1(TAP_EN1), .STANDBY(STANDBY));

  dps_host_model host (
    .CLK_SYS(CLK_SYS), .CS_N(CS_N), .SCK(SCK), .SI(SI),
    .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE));

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [255:0] seen,
                       input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask : cyc

  task automatic pot(input bit p, input logic [7:0] exp);
    check("wiper", p ? WIPER_POS1 : WIPER_POS0, exp);
    check("tap", p ? TAP_EN1 : TAP_EN0, 256'h1 << exp);
  endtask : pot

  task automatic cmd(input logic [3:0] a, input logic [3:0] op,
                     input logic [1:0] r, input bit p, input logic [7:0] d,
                     input int n, input int hold, input bit keep);
    host.xfer({dps_pkg::DEV_TYPE, a, op, r, 1'b0, p, d}, n, hold, keep,
              rd, oe);
    cyc(6);
  endtask : cmd

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    pot(0, dps_pkg::NV_RESET);
    pot(1, dps_pkg::NV_RESET);
    check("oe", SO_OE, 1'b0);
    check("standby", STANDBY, 1'b1);
  endtask : t_reset

  task automatic t_write_read();
    cmd(ADDR, dps_pkg::OP_WR_WIPER, 2'h0, 0, 8'h3C, 24, 11, 0);
    pot(0, 8'h3C);
    cmd(ADDR, dps_pkg::OP_WR_WIPER, 2'h0, 1, 8'hC5, 24, 20, 0);
    pot(1, 8'hC5);
    cmd(ADDR, dps_pkg::OP_RD_WIPER, 2'h0, 1, 8'h00, 24, -1, 0);
    check("read", rd, 8'hC5);
    check("oe read", oe, 1'b1);
    check("oe idle", SO_OE, 1'b0);
  endtask : t_write_read

  task automatic t_bad_addr();
    cmd(ADDR ^ 4'h1, dps_pkg::OP_WR_WIPER, 2'h0, 0, 8'h11, 24, -1, 0);
    pot(0, 8'h3C);
    cmd(ADDR ^ 4'h8, dps_pkg::OP_RD_WIPER, 2'h0, 1, 8'h00, 24, -1, 0);
    check("oe bad", oe, 1'b0);
    host.xfer({~dps_pkg::DEV_TYPE, ADDR, dps_pkg::OP_RD_WIPER, 4'h1,
               8'h00}, 24, -1, 0, rd, oe);
    cyc(6);
    check("oe type", oe, 1'b0);
  endtask : t_bad_addr

  task automatic t_nv();
    int i;
    WP_N = 1'b0;
    cmd(ADDR, dps_pkg::OP_WR_NV, 2'h2, 1, 8'h55, 24, -1, 0);
    check("standby wp", STANDBY, 1'b1);
    WP_N = 1'b1;
    cmd(ADDR, dps_pkg::OP_RD_NV, 2'h2, 1, 8'h00, 24, -1, 0);
    check("nv wp", rd, dps_pkg::NV_RESET);
    cmd(ADDR, dps_pkg::OP_WR_NV, 2'h2, 1, 8'h55, 24, -1, 0);
    check("standby busy", STANDBY, 1'b0);
    for (i = 0; i < NVW + 40 && STANDBY !== 1'b1; i++) begin
      cyc(1);
    end
    check("busy end", STANDBY, 1'b1);
    if (STANDBY !== 1'b1) begin
      end_of_test();
    end
    cmd(ADDR, dps_pkg::OP_RD_NV, 2'h2, 1, 8'h00, 24, -1, 0);
    check("nv", rd, 8'h55);
    cmd(ADDR, dps_pkg::OP_NV_TO_WIP, 2'h2, 1, 8'h00, 16, -1, 0);
    pot(1, 8'h55);
    cmd(ADDR, dps_pkg::OP_WIP_TO_NV, 2'h3, 0, 8'h00, 16, -1, 0);
    check("standby copy", STANDBY, 1'b0);
    for (i = 0; i < NVW + 40 && STANDBY !== 1'b1; i++) begin
      cyc(1);
    end
    check("copy end", STANDBY, 1'b1);
    if (STANDBY !== 1'b1) begin
      end_of_test();
    end
    cmd(ADDR, dps_pkg::OP_RD_NV, 2'h3, 0, 8'h00, 24, -1, 0);
    check("nv copy", rd, 8'h3C);
  endtask : t_nv

  // Reset with select already low: no falling edge, so the frame is ignored.
  task automatic t_no_fall();
    cmd(ADDR, dps_pkg::OP_RD_STATUS, 2'h0, 0, 8'h00, 16, -1, 1);
    check("active", STANDBY, 1'b0);
    NRST = 1'b0;
    cyc(5);
    NRST = 1'b1;
    cyc(2);
    pot(0, dps_pkg::NV_RESET);
    host.xfer({dps_pkg::DEV_TYPE, ADDR, dps_pkg::OP_WR_WIPER, 4'h0,
               8'h22}, 24, -1, 0, rd, oe);
    cyc(6);
    pot(0, dps_pkg::NV_RESET);
    check("oe no fall", oe, 1'b0);
  endtask : t_no_fall

  // ==========================================================================
  // Main sequence
  initial begin
    mismatches      = 0;
    checks          = 0;
    NRST            = 1'b0;
    WP_N            = 1'b1;
    SLAVE_ADDR_PINS = ADDR;
    cyc(5);
    NRST = 1'b1;
    cyc(3);
    t_reset();
    t_write_read();
    t_bad_addr();
    t_nv();
    t_no_fall();
    end_of_test();
  end
endmodule : testbench
